// ### bench/tec_setpoint_controller_tb.sv
// Self-checking bench for the setpoint controller
`timescale 1ns/100ps
`default_nettype none
`include "tsc_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module tec_setpoint_controller_tb;
   import tsc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic sensor_en, tec_en, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, temp_led;
   logic [2:0] hsize;
   tsc_temps_t temps;
   tsc_temp_t temp_housing, tec_target;
   int num_errors = 0;
   int num_checks = 0;
   tsc_temp_t sp_tbl [4] = '{`TSC_SP1, `TSC_SP2, `TSC_SP3, `TSC_SP4};
   int seq [6] = '{0, 1, 2, 3, 2, 1};
   logic [31:0] src_exp [4] = '{32'h1e, 32'h14, 32'h19, 32'hfffffff4};
   logic [7:0] ofs [5] = '{`TSC_OFS_ALERT, `TSC_OFS_MAXDT, `TSC_OFS_HYST,
      `TSC_OFS_IRQ_MASK, 8'h20};
   logic [31:0] rst_exp [5] = '{32'h46, 32'h1e, 32'h3, 32'h0, 32'h0};

   tsc_top #(.SETTLE_CYC(8)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .temps(temps), .temp_housing(temp_housing),
      .sensor_en(sensor_en), .tec_en(tec_en), .tec_target(tec_target),
      .temp_led(temp_led), .irq(irq)
   );
   tsc_plant_model u_plant (
      .hclk(hclk), .tec_en(tec_en), .tec_target(tec_target),
      .temps(temps), .temp_housing(temp_housing)
   );

   // 40 MHz clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // One AHB single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK({hresp, rd}, {1'b0, e})
   endtask

   // Reset doubles as the power cycle
   task automatic do_reset;
      hresetn <= 1'b0;
      cyc(10);
      hresetn <= 1'b1;
      cyc(2);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
      do_reset();
      `CHK(tec_target, sp_tbl[1])
      `CHK(temp_led, 2'b00)
      bus(1'b1, `TSC_OFS_STATUS, 32'hffffffff);
      bus(1'b1, 8'h20, 32'hffffffff);
      rchk(`TSC_OFS_STATUS, 32'h101);
      for (int i = 0; i < 5; i++) begin
         rchk(ofs[i], rst_exp[i]);
      end
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `TSC_OFS_CTRL, {26'h0, i[1:0], 4'h2});
         rchk(`TSC_OFS_READING, src_exp[i]);
      end
      // Manual mode ignores a large difference, follows writes
      bus(1'b1, `TSC_OFS_CTRL, 32'h12);
      u_plant.housing_c <= 12'sd60;
      cyc(20);
      `CHK(tec_target, sp_tbl[1])
      `CHK(temp_led, 2'b01)
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, `TSC_OFS_CTRL, {26'h0, 2'h1, 1'b0, seq[i][1:0], 1'b0});
         cyc(12);
         `CHK(tec_target, sp_tbl[seq[i]])
      end
      // Automatic mode: exactly at the margin, then one past it
      u_plant.housing_c <= 12'sd53;
      bus(1'b1, `TSC_OFS_CTRL, 32'h13);
      cyc(20);
      `CHK(tec_target, sp_tbl[1])
      u_plant.housing_c <= 12'sd54;
      cyc(12);
      `CHK(tec_target, sp_tbl[2])
      rchk(`TSC_OFS_IRQ_STAT, 32'h1);
      u_plant.housing_c <= 12'sd69;
      cyc(12);
      `CHK(tec_target, sp_tbl[3])
      u_plant.housing_c <= 12'sd90;
      cyc(20);
      `CHK({irq, tec_target}, {1'b0, sp_tbl[3]})
      bus(1'b1, `TSC_OFS_IRQ_STAT, 32'h7);
      bus(1'b1, `TSC_OFS_IRQ_MASK, 32'h7);
      // Sensor below setpoint walks down to the bottom
      u_plant.housing_c <= 12'sd30;
      u_plant.err_c <= -12'sd4;
      cyc(60);
      `CHK({irq, tec_target}, {1'b1, sp_tbl[0]})
      rchk(`TSC_OFS_IRQ_STAT, 32'h2);
      bus(1'b1, `TSC_OFS_IRQ_STAT, 32'h2);
      cyc(3);
      `CHK(irq, 1'b0)
      // Over-temperature: limit itself, then one above
      u_plant.err_c <= 12'sd0;
      u_plant.mboard_c <= 12'sd70;
      cyc(5);
      `CHK(sensor_en, 1'b1)
      u_plant.mboard_c <= 12'sd71;
      cyc(3);
      `CHK({sensor_en, tec_en, temp_led[1], irq}, 4'b0011)
      bus(1'b0, `TSC_OFS_STATUS, 32'h0);
      `CHK(rd[2], 1'b1)
      u_plant.mboard_c <= 12'sd25;
      bus(1'b1, `TSC_OFS_CTRL, 32'h12);
      cyc(20);
      `CHK({sensor_en, tec_en}, 2'b00)
      do_reset();
      `CHK({sensor_en, tec_en, tec_target}, {2'b11, sp_tbl[1]})
      rchk(`TSC_OFS_CTRL, 32'h12);
      tally_and_finish();
   end

   // Watchdog, far beyond the expected few hundred cycles
   initial begin
      cyc(20000);
      num_errors++;
      tally_and_finish();
   end
endmodule // tec_setpoint_controller_tb
`default_nettype wire

// ### bench/tsc_plant_model.sv
// Behavioural cooler and on-board temperature sensors
`timescale 1ns/100ps
`default_nettype none
module tsc_plant_model (
   input wire logic hclk,
   input wire logic tec_en,
   input wire tsc_pkg::tsc_temp_t tec_target,
   output tsc_pkg::tsc_temps_t temps,
   output tsc_pkg::tsc_temp_t temp_housing
);
   import tsc_pkg::*;
   // Ambient conditions, moved by the bench between scenarios
   tsc_temp_t housing_c = 12'sd20;
   tsc_temp_t err_c = 12'sd0;
   tsc_temp_t mboard_c = -12'sd12;
   tsc_temp_t sensor_q = 12'sd20;
   // Cooler holds the sensor off its target by err; unpowered it drifts
   always @(posedge hclk) begin
      sensor_q <= tec_en ? tec_target + err_c : housing_c;
   end
   // Negative main board reading exercises sign extension
   assign temps = {12'sd30, sensor_q, 12'sd25, mboard_c};
   assign temp_housing = housing_c;
endmodule // tsc_plant_model
`default_nettype wire

// ### bench/tsc_top_props.sv
// Port-level assertion checker for the setpoint controller
`timescale 1ns/100ps
`default_nettype none
`include "tsc_defs.svh"
module tsc_top_props #(
   parameter int SETTLE_CYC = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire tsc_pkg::tsc_temps_t temps,
   input wire logic sensor_en,
   input wire logic tec_en,
   input wire tsc_pkg::tsc_temp_t tec_target,
   input wire logic [1:0] temp_led
);
   import tsc_pkg::*;
   // Assumes software leaves the alert limit at its reset value
   localparam tsc_temp_t ALERT = `TSC_ALERT_RST;
   logic hot;
   // Any reading strictly above the alert limit
   assign hot = temps.phy > ALERT || temps.sensor > ALERT ||
      temps.sboard > ALERT || temps.mboard > ALERT;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   over_alert_off_a: assert property (hot |=> !sensor_en && !tec_en)
      else $error("no shutdown after over temperature");
   both_off_a: assert property (sensor_en == tec_en)
      else $error("sensor and cooler enables differ");
   off_sticky_a: assert property ($fell(sensor_en) |=>
      !sensor_en [*8]) else $error("shutdown released without power cycle");
   led_shows_off_a: assert property ($fell(sensor_en) |->
      temp_led[1]) else $error("status indicator misses shutdown");
   target_in_set_a: assert property (tec_target inside {`TSC_SP1,
      `TSC_SP2, `TSC_SP3, `TSC_SP4}) else $error("target not a setpoint");
   step_adjacent_a: assert property ($changed(tec_target) |->
      (tec_target - $past(tec_target)) inside {15, -15})
      else $error("setpoint jumped beyond neighbour");
   settle_hold_a: assert property ($changed(tec_target) |=>
      $stable(tec_target) [*6]) else $error("setpoint changed while settling");
   power_up_a: assert property (!$past(hresetn) |->
      tec_target == `TSC_SP2) else $error("not at default after reset");
   // Main scenarios reached
   cover property (tec_target > $past(tec_target));
   cover property (tec_target < $past(tec_target));
   cover property ($fell(sensor_en));
endmodule // tsc_top_props
bind tsc_top tsc_top_props #(.SETTLE_CYC(SETTLE_CYC)) u_props (
   .hclk(hclk),
   .hresetn(hresetn),
   .temps(temps),
   .sensor_en(sensor_en),
   .tec_en(tec_en),
   .tec_target(tec_target),
   .temp_led(temp_led)
);
`default_nettype wire

// ### inc/tsc_defs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// Register byte offsets
`define TSC_OFS_CTRL 8'h00
`define TSC_OFS_STATUS 8'h04
`define TSC_OFS_READING 8'h08
`define TSC_OFS_ALERT 8'h0c
`define TSC_OFS_MAXDT 8'h10
`define TSC_OFS_HYST 8'h14
`define TSC_OFS_IRQ_STAT 8'h18
`define TSC_OFS_IRQ_MASK 8'h1c

// Control register fields
`define TSC_CTRL_AUTO 0
`define TSC_CTRL_SP 2:1
`define TSC_CTRL_SRC 5:4

// Status register fields
`define TSC_STAT_SP 1:0
`define TSC_STAT_OFF 2
`define TSC_STAT_AUTO 3
`define TSC_STAT_SETTLE 4
`define TSC_STAT_SRC 9:8

// Interrupt bits
`define TSC_IRQ_UP 0
`define TSC_IRQ_DOWN 1
`define TSC_IRQ_SHUT 2
`define TSC_IRQ_W 3

// Setpoints in whole degrees Celsius, two's complement
`define TSC_SP1 12'h005
`define TSC_SP2 12'h014
`define TSC_SP3 12'h023
`define TSC_SP4 12'h032
`define TSC_SP_DEFAULT 2'h1
`define TSC_SP_TOP 2'h3
`define TSC_SP_BOTTOM 2'h0

// Reset values of software-set limits
`define TSC_ALERT_RST 12'h046
`define TSC_MAXDT_RST 12'h01e
`define TSC_HYST_RST 12'h003
`define TSC_SRC_RST 2'h1

// Settling time after a step and clock rate
`define TSC_SETTLE_MS 1
`define TSC_CLK_KHZ 40000
`define TSC_SETTLE_CYC (`TSC_SETTLE_MS * `TSC_CLK_KHZ)

`endif

// ### inc/tsc_pkg.sv
// Types shared by the temperature setpoint controller files
`default_nettype none
package tsc_pkg;

   typedef logic signed [11:0] tsc_temp_t;

   typedef enum logic [1:0] {
      TSC_SRC_PHY,
      TSC_SRC_SENSOR,
      TSC_SRC_SBOARD,
      TSC_SRC_MBOARD
   } tsc_src_t;

   typedef enum logic {
      TSC_MANUAL,
      TSC_AUTO
   } tsc_mode_t;

   typedef enum logic [1:0] {
      TSC_RUN,
      TSC_SETTLE,
      TSC_OFF
   } tsc_state_t;

   // All four on-board readings, whole degrees Celsius
   typedef struct packed {
      tsc_temp_t phy;
      tsc_temp_t sensor;
      tsc_temp_t sboard;
      tsc_temp_t mboard;
   } tsc_temps_t;

endpackage
`default_nettype wire

// ### logic/tsc_temp_mux.sv
// Selects one temperature reading and finds the hottest one
`timescale 1ns/100ps
`default_nettype none
module tsc_temp_mux (
   input wire tsc_pkg::tsc_temps_t temps,
   input wire tsc_pkg::tsc_src_t src,
   output logic signed [11:0] reading,
   output logic signed [11:0] hottest
);
   import tsc_pkg::*;

   tsc_temp_t hot_a;
   tsc_temp_t hot_b;

   // Readout follows the chosen source
   always_comb begin
      case (src)
         TSC_SRC_PHY: reading = temps.phy;
         TSC_SRC_SENSOR: reading = temps.sensor;
         TSC_SRC_SBOARD: reading = temps.sboard;
         default: reading = temps.mboard;
      endcase
   end

   // Any sensor may carry the alarm, so compare all four
   always_comb begin
      hot_a = (temps.phy > temps.sensor) ? temps.phy : temps.sensor;
      hot_b = (temps.sboard > temps.mboard) ? temps.sboard : temps.mboard;
      hottest = (hot_a > hot_b) ? hot_a : hot_b;
   end

endmodule // tsc_temp_mux
`default_nettype wire

// ### logic/tsc_top.sv
// Thermoelectric setpoint controller with its AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "tsc_defs.svh"

// Notes on behaviour
// - Four setpoints; first +5, default +20 degrees.
// - Four selectable temperature sources, sensor default.
// - Readout returns the currently selected source.
// - Manual or automatic mode; auto steps adjacent.
// - Auto steps only after a hysteresis margin.
// - Difference above maximum steps to higher setpoint.
// - Difference within maximum keeps current setpoint.
// - Sensor below setpoint steps to lower setpoint.
// - Over alert limit disables sensor and cooler.
// - Shutdown holds until power is cycled.
// - Status indicator shows sensor and camera temperature.
// - After power-up regulate toward default setpoint.
// - Mode selection resets to manual.
module tsc_top #(
   parameter int SETTLE_CYC = `TSC_SETTLE_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire tsc_pkg::tsc_temps_t temps,
   input wire tsc_pkg::tsc_temp_t temp_housing,
   output logic sensor_en,
   output logic tec_en,
   output tsc_pkg::tsc_temp_t tec_target,
   output logic [1:0] temp_led,
   output logic irq
);
   import tsc_pkg::*;

   // Setpoint index to temperature, used for target and step-down test
   // Setpoints are fixed at build time; software picks one by index
   function automatic tsc_temp_t sp_temp(input logic [1:0] idx);
      case (idx)
         2'h0: sp_temp = `TSC_SP1;
         2'h1: sp_temp = `TSC_SP2;
         2'h2: sp_temp = `TSC_SP3;
         default: sp_temp = `TSC_SP4;
      endcase
   endfunction

   // Bus and register state
   logic wr_q;
   logic [7:0] waddr_q;
   logic hreadyout_q;
   logic hresp_q;
   logic [31:0] hrdata_q;
   tsc_mode_t mode_q;
   tsc_src_t src_q;
   tsc_temp_t alert_q;
   tsc_temp_t maxdt_q;
   tsc_temp_t hyst_q;
   logic [`TSC_IRQ_W-1:0] irq_stat_q;
   logic [`TSC_IRQ_W-1:0] irq_mask_q;
   logic irq_q;

   // Controller state
   tsc_state_t state_q;
   logic [1:0] sp_q;
   logic [15:0] settle_q;
   logic sensor_en_q;
   logic tec_en_q;
   tsc_temp_t tec_target_q;
   logic [1:0] led_q;

   // Combinational helpers
   logic addr_ok;
   logic [31:0] rdata_d;
   logic wr_ctrl;
   tsc_temp_t reading;
   tsc_temp_t hottest;
   logic signed [12:0] dt;
   logic signed [12:0] up_lim;
   logic signed [12:0] dn_lim;
   logic over;
   logic step_up;
   logic step_dn;
   logic off_target;
   logic below_lo;
   logic above_hi;
   logic [`TSC_IRQ_W-1:0] ev;

   // Readout and alarm both come from the four on-board sensors
   tsc_temp_mux u_mux (
      .temps(temps),
      .src(src_q),
      .reading(reading),
      .hottest(hottest)
   );

   // Address phase accepted only with hready high and a NONSEQ/SEQ
   // hsize and htrans[0] are not decoded: every access is one word
   assign addr_ok = hsel & htrans[1] & hready;
   assign wr_ctrl = wr_q & (waddr_q == `TSC_OFS_CTRL);

   // Read mux; unmapped offsets read as zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (haddr[7:0])
         `TSC_OFS_CTRL: begin
            rdata_d[`TSC_CTRL_AUTO] = (mode_q == TSC_AUTO);
            rdata_d[`TSC_CTRL_SP] = sp_q;
            rdata_d[`TSC_CTRL_SRC] = src_q;
         end
         `TSC_OFS_STATUS: begin
            rdata_d[`TSC_STAT_SP] = sp_q;
            rdata_d[`TSC_STAT_OFF] = (state_q == TSC_OFF);
            rdata_d[`TSC_STAT_AUTO] = (mode_q == TSC_AUTO);
            rdata_d[`TSC_STAT_SETTLE] = (state_q == TSC_SETTLE);
            rdata_d[`TSC_STAT_SRC] = src_q;
         end
         `TSC_OFS_READING: rdata_d = {{20{reading[11]}}, reading};
         `TSC_OFS_ALERT: rdata_d[11:0] = alert_q;
         `TSC_OFS_MAXDT: rdata_d[11:0] = maxdt_q;
         `TSC_OFS_HYST: rdata_d[11:0] = hyst_q;
         `TSC_OFS_IRQ_STAT: rdata_d[`TSC_IRQ_W-1:0] = irq_stat_q;
         `TSC_OFS_IRQ_MASK: rdata_d[`TSC_IRQ_W-1:0] = irq_mask_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // Slave never stalls and always answers OKAY
   // Low in reset, so no transfer is taken before the block is up
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b0;
         hresp_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // Reads are sampled in the address phase, so data stand without wait
   // A read just after a write to the same register sees the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         hrdata_q <= rdata_d;
      end
   end

   // Writes are remembered for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         waddr_q <= 8'h00;
      end else begin
         wr_q <= addr_ok & hwrite;
         if (addr_ok) begin
            waddr_q <= haddr[7:0];
         end
      end
   end

   // Mode and source selection
   // With the auto bit set, the setpoint field of the write is ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= TSC_MANUAL;
         src_q <= tsc_src_t'(`TSC_SRC_RST);
      end else if (wr_ctrl) begin
         mode_q <= hwdata[`TSC_CTRL_AUTO] ? TSC_AUTO : TSC_MANUAL;
         src_q <= tsc_src_t'(hwdata[`TSC_CTRL_SRC]);
      end
   end

   // Software-set limits
   // New limits take effect at the next compare, without a settle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alert_q <= `TSC_ALERT_RST;
         maxdt_q <= `TSC_MAXDT_RST;
         hyst_q <= `TSC_HYST_RST;
      end else if (wr_q) begin
         if (waddr_q == `TSC_OFS_ALERT) begin
            alert_q <= hwdata[11:0];
         end
         if (waddr_q == `TSC_OFS_MAXDT) begin
            maxdt_q <= hwdata[11:0];
         end
         if (waddr_q == `TSC_OFS_HYST) begin
            hyst_q <= hwdata[11:0];
         end
      end
   end

   // Housing minus sensor; positive while the cooler pulls the sensor down
   // Thirteen bits, so the difference of two extremes cannot wrap
   assign dt = 13'(temp_housing) - 13'(temps.sensor);
   // A margin beyond the limit stops chatter at the threshold
   assign up_lim = 13'(maxdt_q) + 13'(hyst_q);
   assign dn_lim = 13'(sp_temp(sp_q)) - 13'(hyst_q);
   assign over = hottest > alert_q;
   assign step_up = (dt > up_lim) && (sp_q != `TSC_SP_TOP);
   // Band around the active setpoint, shared by stepping and indicator
   assign below_lo = 13'(temps.sensor) < dn_lim;
   assign above_hi = 13'(temps.sensor) > 13'(sp_temp(sp_q)) + 13'(hyst_q);
   assign step_dn = below_lo && (sp_q != `TSC_SP_BOTTOM);
   // Any of the three leaves the sensor visibly off its setpoint
   assign off_target = (dt > 13'(maxdt_q)) || below_lo || above_hi;

   // Controller: regulate, step, wait to settle, or stay shut down
   // SETTLE_CYC must not exceed 65536 to fit the 16-bit counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= TSC_RUN;
         sp_q <= `TSC_SP_DEFAULT;
         settle_q <= 16'h0000;
      end else begin
         case (state_q)
            TSC_RUN: begin
               // Over-temperature beats any step
               if (over) begin
                  state_q <= TSC_OFF;
               end else if (mode_q == TSC_AUTO && step_up) begin
                  sp_q <= sp_q + 2'h1;
                  settle_q <= 16'h0000;
                  state_q <= TSC_SETTLE;
               end else if (mode_q == TSC_AUTO && step_dn) begin
                  sp_q <= sp_q - 2'h1;
                  settle_q <= 16'h0000;
                  state_q <= TSC_SETTLE;
               end else if (mode_q == TSC_MANUAL && wr_ctrl
                  && !hwdata[`TSC_CTRL_AUTO]) begin
                  sp_q <= hwdata[`TSC_CTRL_SP];
               end else begin
                  // Within the cooler's reach: keep the setpoint
                  sp_q <= sp_q;
               end
            end
            TSC_SETTLE: begin
               // Give the cooler time before judging the new setpoint
               if (over) begin
                  state_q <= TSC_OFF;
               end else if (settle_q == 16'(SETTLE_CYC - 1)) begin
                  state_q <= TSC_RUN;
               end else begin
                  settle_q <= settle_q + 16'h0001;
               end
            end
            TSC_OFF: begin
               // Only hresetn, standing in for a power cycle, leaves here
               state_q <= TSC_OFF;
            end
            default: begin
               state_q <= TSC_OFF;
            end
         endcase
      end
   end

   // Enables and target; only reset leaves the shutdown
   // over is used directly so the cut does not wait for the state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sensor_en_q <= 1'b0;
         tec_en_q <= 1'b0;
         tec_target_q <= `TSC_SP2;
      end else begin
         sensor_en_q <= (state_q != TSC_OFF) && !over;
         tec_en_q <= (state_q != TSC_OFF) && !over;
         tec_target_q <= sp_temp(sp_q);
      end
   end

   // Indicator: bit 0 sensor off its setpoint, bit 1 camera too hot
   // Bit 0 is held off while shut down, as the sensor is then unpowered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         led_q <= 2'h0;
      end else begin
         led_q[0] <= off_target && (state_q != TSC_OFF);
         led_q[1] <= over || (state_q == TSC_OFF);
      end
   end

   // Events: step up, step down, shutdown entry
   // Same priorities as the controller, so a flag means a real step
   always_comb begin
      ev = '0;
      ev[`TSC_IRQ_UP] = (state_q == TSC_RUN) && !over
         && (mode_q == TSC_AUTO) && step_up;
      ev[`TSC_IRQ_DOWN] = (state_q == TSC_RUN) && !over
         && (mode_q == TSC_AUTO) && !step_up && step_dn;
      ev[`TSC_IRQ_SHUT] = (state_q != TSC_OFF) && over;
   end

   // Sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_q <= '0;
      end else if (wr_q && waddr_q == `TSC_OFS_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~hwdata[`TSC_IRQ_W-1:0]) | ev;
      end else begin
         irq_stat_q <= irq_stat_q | ev;
      end
   end

   // Mask register, same layout as status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask_q <= '0;
      end else if (wr_q && waddr_q == `TSC_OFS_IRQ_MASK) begin
         irq_mask_q <= hwdata[`TSC_IRQ_W-1:0];
      end
   end

   // Level interrupt, one cycle behind the status bits
   // Registered so that irq comes straight from a flip-flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Every output is driven from its own flip-flop
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign hrdata = hrdata_q;
   assign sensor_en = sensor_en_q;
   assign tec_en = tec_en_q;
   assign tec_target = tec_target_q;
   assign temp_led = led_q;
   assign irq = irq_q;

endmodule // tsc_top
`default_nettype wire
